// file: hw/supervisor_trap_irq_csrs.sv
`timescale 1ns/1ps
`default_nettype none
`include "sup_csr_consts.svh"

module supervisor_trap_irq_csrs #(
  parameter bit          USER_IRQ_EN    = 1'b1,
  parameter int          VEC_ALIGN_BITS = 2,
  parameter logic [31:0] GATE_IMPL      = 32'hffff_ffff,
  parameter int          CAUSE_W        = 5
) (
  // Clock and reset
  input  wire logic                      ref_clk_i,
  input  wire logic                      rstn_i,
  // CSR access from the instruction pipeline
  input  wire logic                      csr_req_i,
  input  wire logic [`SC_ADDR_W-1:0]     csr_addr_i,
  input  wire sup_csr_pkg::csr_op_e      csr_op_i,
  input  wire logic [31:0]               csr_wdata_i,
  output logic                           csr_ack_o,
  output logic                           csr_err_o,
  output logic      [31:0]               csr_rdata_o,
  // Interrupt sources
  input  wire logic                      ipi_i,
  input  wire logic                      sup_ext_irq_i,
  input  wire logic                      user_ext_irq_i,
  input  wire logic                      user_timer_irq_i,
  input  wire logic [31:0]               time_i,
  // Enabled and pending interrupts towards the trap logic
  output logic      [31:0]               irq_active_o,
  // Trap dispatch
  input  wire logic                      trap_i,
  input  wire logic                      trap_irq_i,
  input  wire logic [CAUSE_W-1:0]        trap_cause_i,
  output logic                           trap_pc_valid_o,
  output logic      [31:0]               trap_pc_o,
  // User counter reads
  input  wire logic                      cnt_rd_i,
  input  wire logic                      user_mode_i,
  input  wire logic [4:0]                cnt_idx_i,
  output logic                           cnt_ok_o,
  output logic                           cnt_illegal_o
);

  import sup_csr_pkg::*;

  if (VEC_ALIGN_BITS < `SC_MIN_ALIGN || VEC_ALIGN_BITS > 30) begin : g_bad_align
    $error("VEC_ALIGN_BITS must lie between 2 and 30");
  end
  if (CAUSE_W < 4 || CAUSE_W > 10) begin : g_bad_cause
    $error("CAUSE_W must lie between 4 and 10");
  end

  // Reset release. The pin acts at once, but its release passes two flops, so no
  // register leaves reset in the cycle in which the pin rises.

  logic rst_meta_reg;
  logic rst_sync_reg;

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  wire rst_n = rst_sync_reg;

  // Writable masks. Bits 3, 7 and 11 stay outside every mask.

  localparam logic [31:0] USER_MASK = USER_IRQ_EN ? `SC_ENAB_MASK_U : 32'h0;
  localparam logic [31:0] ENAB_MASK = `SC_ENAB_MASK_S | USER_MASK;
  localparam logic [31:0] PEND_MASK = `SC_PEND_MASK_S | (USER_MASK & `SC_PEND_MASK_U);

  // Address decode.
  // The address is decoded whatever the request; only a qualified write acts.

  wire hit_tvec = csr_addr_i == `SC_ADDR_TVEC;
  wire hit_pend = csr_addr_i == `SC_ADDR_PEND;
  wire hit_enab = csr_addr_i == `SC_ADDR_ENAB;
  wire hit_gate = csr_addr_i == `SC_ADDR_GATE;
  wire hit_tcmp = csr_addr_i == `SC_ADDR_TCMP;
  wire mapped   = hit_tvec | hit_pend | hit_enab | hit_gate | hit_tcmp;
  wire do_write = csr_req_i && mapped && (csr_op_i != CSR_READ);

  wire wr_tvec = do_write && hit_tvec;
  wire wr_pend = do_write && hit_pend;
  wire wr_enab = do_write && hit_enab;
  wire wr_gate = do_write && hit_gate;
  wire wr_tcmp = do_write && hit_tcmp;

  // One read-modify-write helper serves every view, so set and clear always act
  // on the stored bits and never on live request lines.
  function automatic logic [31:0] rmw(input csr_op_e op,
                                      input logic [31:0] old,
                                      input logic [31:0] wd);
    logic [31:0] res;
    res = old;
    unique case (op)
      CSR_WRITE: res = wd;
      CSR_SET:   res = old | wd;
      CSR_CLEAR: res = old & ~wd;
      CSR_READ:  res = old;
    endcase
    return res;
  endfunction : rmw

  // State.

  logic        user_soft_pending_reg;
  logic        sup_soft_pending_reg;
  logic        user_ext_pending_sw_reg;
  logic        sup_timer_pending_reg;
  logic [31:0] enab_reg;
  logic [31:2] tvec_base_reg;
  logic        tvec_vec_reg;
  logic [31:0] gate_reg;
  logic [31:0] tcmp_reg;

  // Pending view. The writable-software copy keeps the user external flop alone,
  // so a set or clear never latches the controller line into it.

  logic [31:0] pend_sw;
  logic [31:0] pend_view;

  always_comb begin
    pend_sw                 = `SC_RST_WORD;
    pend_sw[`SC_BIT_USOFT]  = user_soft_pending_reg;
    pend_sw[`SC_BIT_SSOFT]  = sup_soft_pending_reg;
    pend_sw[`SC_BIT_UEXT]   = user_ext_pending_sw_reg;
    pend_sw[`SC_BIT_UTIMER] = user_timer_irq_i && USER_IRQ_EN;
    pend_sw[`SC_BIT_STIMER] = sup_timer_pending_reg;
    pend_sw[`SC_BIT_SEXT]   = sup_ext_irq_i;
  end

  always_comb begin
    pend_view = pend_sw;
    pend_view[`SC_BIT_UEXT] = (user_ext_pending_sw_reg | user_ext_irq_i) && USER_IRQ_EN;
  end

  wire [31:0] pend_new = rmw(csr_op_i, pend_sw, csr_wdata_i);
  wire [31:0] enab_new = rmw(csr_op_i, enab_reg, csr_wdata_i);
  wire [31:0] gate_new = rmw(csr_op_i, gate_reg, csr_wdata_i);
  wire [31:0] tcmp_new = rmw(csr_op_i, tcmp_reg, csr_wdata_i);

  // Software pending bits. The interprocessor request wins over a clearing write.

  wire sup_soft_pending_next = ipi_i ? 1'b1
                 : (wr_pend ? pend_new[`SC_BIT_SSOFT] : sup_soft_pending_reg);
  wire user_soft_pending_next = (wr_pend && PEND_MASK[`SC_BIT_USOFT]) ?
                   pend_new[`SC_BIT_USOFT] : user_soft_pending_reg;
  wire user_ext_pending_next = (wr_pend && PEND_MASK[`SC_BIT_UEXT]) ?
                   pend_new[`SC_BIT_UEXT] : user_ext_pending_sw_reg;

  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      user_soft_pending_reg    <= 1'b0;
      sup_soft_pending_reg    <= 1'b0;
      user_ext_pending_sw_reg <= 1'b0;
    end else begin
      user_soft_pending_reg    <= user_soft_pending_next;
      sup_soft_pending_reg    <= sup_soft_pending_next;
      user_ext_pending_sw_reg <= user_ext_pending_next;
    end
  end

  // Enable view. Non-writable positions keep their value, which is zero.
  // Writes that reach bits 3, 7 and 11 are dropped, as those belong to machine level.

  wire [31:0] enab_next = wr_enab ? ((enab_new & ENAB_MASK) | (enab_reg & ~ENAB_MASK))
                                  : enab_reg;

  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      enab_reg <= `SC_RST_WORD;
    end else begin
      enab_reg <= enab_next;
    end
  end

  // Timer scheduling. Software clears the supervisor timer by moving the compare
  // value past the current time; the pending bit itself ignores writes.

  wire [31:0] tcmp_next  = wr_tcmp ? tcmp_new : tcmp_reg;
  wire        timer_due  = time_i >= tcmp_reg;

  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      tcmp_reg <= `SC_RST_TCMP;
      sup_timer_pending_reg <= 1'b0;
    end else begin
      tcmp_reg <= tcmp_next;
      sup_timer_pending_reg <= timer_due && !wr_tcmp;
    end
  end

  // Trap vector. A reserved mode leaves the stored mode unchanged. In vectored
  // mode the low base bits below the stricter alignment are forced to zero.

  logic [31:0] tvec_view;

  assign tvec_view = {tvec_base_reg, 1'b0, tvec_vec_reg};

  wire [31:0] tvec_new   = rmw(csr_op_i, tvec_view, csr_wdata_i);
  wire [1:0]  mode_field = tvec_new[`SC_MODE_LO +: 2];
  wire        mode_legal = (mode_field == VEC_DIRECT) || (mode_field == VEC_VECTORED);
  wire        vec_next   = mode_legal ? (mode_field == VEC_VECTORED) : tvec_vec_reg;

  localparam logic [31:0] VEC_ALIGN_MASK = ~((32'h1 << VEC_ALIGN_BITS) - 32'h1);

  wire [31:0] base_wr   = vec_next ? (tvec_new & VEC_ALIGN_MASK) : tvec_new;
  wire [31:2] base_next = wr_tvec ? base_wr[31:`SC_BASE_LO] : tvec_base_reg;
  wire        tvec_mode_next = wr_tvec ? vec_next : tvec_vec_reg;

  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      tvec_base_reg <= '0;
      tvec_vec_reg  <= 1'b0;
    end else begin
      tvec_base_reg <= base_next;
      tvec_vec_reg  <= tvec_mode_next;
    end
  end

  // Counter gates. Unimplemented gates read as zero and trap every user-mode read.

  wire [31:0] gate_next = wr_gate ? (gate_new & GATE_IMPL) : gate_reg;

  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      gate_reg <= `SC_RST_WORD;
    end else begin
      gate_reg <= gate_next;
    end
  end

  // Read data. The old value is returned, as for a swap.
  // Unmapped addresses read as zero and raise the error flag instead.

  logic [31:0] rd_value;

  always_comb begin
    rd_value = `SC_RST_WORD;
    if (hit_tvec) begin
      rd_value = tvec_view;
    end
    if (hit_pend) begin
      rd_value = pend_view;
    end
    if (hit_enab) begin
      rd_value = enab_reg;
    end
    if (hit_gate) begin
      rd_value = gate_reg;
    end
    if (hit_tcmp) begin
      rd_value = tcmp_reg;
    end
  end

  // Every request is answered one cycle later, so the pipeline never waits here.
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      csr_ack_o   <= 1'b0;
      csr_err_o   <= 1'b0;
      csr_rdata_o <= `SC_RST_WORD;
    end else begin
      csr_ack_o   <= csr_req_i;
      csr_err_o   <= csr_req_i && !mapped;
      csr_rdata_o <= (csr_req_i && mapped) ? rd_value : `SC_RST_WORD;
    end
  end

  // Interrupt gating towards the hart.
  // The hart still applies its global enable and privilege checks on top.

  wire [31:0] irq_next = pend_view & enab_reg;

  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      irq_active_o <= `SC_RST_WORD;
    end else begin
      irq_active_o <= irq_next;
    end
  end

  // Trap target.
  // The target is registered and held, so the fetch logic may take it late.

  logic [31:0] target;

  trap_target_calc #(
    .CAUSE_W (CAUSE_W)
  ) u_target (
    .base_i     ({tvec_base_reg, 2'b00}),
    .vectored_i (tvec_vec_reg),
    .is_irq_i   (trap_irq_i),
    .cause_i    (trap_cause_i),
    .target_o   (target)
  );

  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      trap_pc_valid_o <= 1'b0;
      trap_pc_o       <= `SC_RST_WORD;
    end else begin
      trap_pc_valid_o <= trap_i;
      if (trap_i) begin
        trap_pc_o <= target;
      end
    end
  end

  // User counter read check.
  // Outside user mode every counter read is allowed, whatever the gates say.

  logic cnt_bad;
  logic cnt_good;

  counter_gate_check u_gate (
    .gate_i      (gate_reg),
    .read_i      (cnt_rd_i),
    .user_mode_i (user_mode_i),
    .index_i     (cnt_idx_i),
    .illegal_o   (cnt_bad),
    .allowed_o   (cnt_good)
  );

  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ok_o      <= 1'b0;
      cnt_illegal_o <= 1'b0;
    end else begin
      cnt_ok_o      <= cnt_good;
      cnt_illegal_o <= cnt_bad;
    end
  end

endmodule : supervisor_trap_irq_csrs
`default_nettype wire

// file: hw/sup_csr_consts.svh
`ifndef SUP_CSR_CONSTS_SVH
`define SUP_CSR_CONSTS_SVH

`define SC_ADDR_W        12
`define SC_ADDR_TVEC     12'h105
`define SC_ADDR_PEND     12'h144
`define SC_ADDR_ENAB     12'h104
`define SC_ADDR_GATE     12'h106
`define SC_ADDR_TCMP     12'h5c0

`define SC_BIT_USOFT     0
`define SC_BIT_SSOFT     1
`define SC_BIT_UTIMER    4
`define SC_BIT_STIMER    5
`define SC_BIT_UEXT      8
`define SC_BIT_SEXT      9

`define SC_MODE_LO       0
`define SC_BASE_LO       2
`define SC_MIN_ALIGN     2

`define SC_ENAB_MASK_S   32'h0000_0222
`define SC_ENAB_MASK_U   32'h0000_0111
`define SC_PEND_MASK_S   32'h0000_0002
`define SC_PEND_MASK_U   32'h0000_0101

`define SC_RST_WORD      32'h0000_0000
`define SC_RST_TCMP      32'hffff_ffff

`endif

// file: hw/sup_csr_pkg.sv
package sup_csr_pkg;

  typedef enum logic [1:0] {
    CSR_READ  = 2'b00,
    CSR_WRITE = 2'b01,
    CSR_SET   = 2'b10,
    CSR_CLEAR = 2'b11
  } csr_op_e;

  typedef enum logic [1:0] {
    VEC_DIRECT   = 2'b00,
    VEC_VECTORED = 2'b01
  } vec_mode_e;

endpackage : sup_csr_pkg

// file: hw/trap_target_calc.sv
`timescale 1ns/1ps
`default_nettype none
`include "sup_csr_consts.svh"

module trap_target_calc #(
  parameter int CAUSE_W = 5
) (
  // Vector configuration
  input  wire logic [31:0]        base_i,
  input  wire logic               vectored_i,
  // Trap being taken
  input  wire logic               is_irq_i,
  input  wire logic [CAUSE_W-1:0] cause_i,
  // Target address
  output logic      [31:0]        target_o
);

  logic [31:0] offset;

  // Cause zero gives a zero offset, so it shares the exception target.
  assign offset   = 32'({cause_i, 2'b00});
  assign target_o = (vectored_i && is_irq_i) ? base_i + offset : base_i;

endmodule : trap_target_calc
`default_nettype wire

// file: hw/counter_gate_check.sv
`timescale 1ns/1ps
`default_nettype none

module counter_gate_check (
  // Gate configuration
  input  wire logic [31:0] gate_i,
  // Counter read from the pipeline
  input  wire logic        read_i,
  input  wire logic        user_mode_i,
  input  wire logic [4:0]  index_i,
  // Verdict
  output logic             illegal_o,
  output logic             allowed_o
);

  logic gate_open;

  assign gate_open = gate_i[index_i];
  assign illegal_o = read_i && user_mode_i && !gate_open;
  assign allowed_o = read_i && !illegal_o;

endmodule : counter_gate_check
`default_nettype wire

// file: sim/sup_csr_checker_sva.sv
`timescale 1ns/1ps
`default_nettype none
`include "sup_csr_consts.svh"

module sup_csr_checker
  import sup_csr_pkg::*;
#(
  parameter bit USER_IRQ_EN = 1'b1,
  parameter int CAUSE_W     = 5
) (
  // Clock and reset
  input wire logic                  ref_clk_i,
  input wire logic                  rstn_i,
  // CSR access
  input wire logic                  csr_req_i,
  input wire logic [`SC_ADDR_W-1:0] csr_addr_i,
  input wire sup_csr_pkg::csr_op_e  csr_op_i,
  input wire logic [31:0]           csr_wdata_i,
  input wire logic                  csr_ack_o,
  input wire logic                  csr_err_o,
  input wire logic [31:0]           csr_rdata_o,
  // Interrupts
  input wire logic                  ipi_i,
  input wire logic                  sup_ext_irq_i,
  input wire logic                  user_ext_irq_i,
  input wire logic                  user_timer_irq_i,
  input wire logic [31:0]           time_i,
  input wire logic [31:0]           irq_active_o,
  // Trap dispatch
  input wire logic                  trap_i,
  input wire logic                  trap_irq_i,
  input wire logic [CAUSE_W-1:0]    trap_cause_i,
  input wire logic                  trap_pc_valid_o,
  input wire logic [31:0]           trap_pc_o,
  // Counter reads
  input wire logic                  cnt_rd_i,
  input wire logic                  user_mode_i,
  input wire logic [4:0]            cnt_idx_i,
  input wire logic                  cnt_ok_o,
  input wire logic                  cnt_illegal_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);

  wire logic pend_sel = csr_req_i && csr_addr_i == `SC_ADDR_PEND;
  wire logic enab_sel = csr_req_i && csr_addr_i == `SC_ADDR_ENAB;
  wire logic mapped   = pend_sel || enab_sel || csr_addr_i == `SC_ADDR_TVEC ||
                        csr_addr_i == `SC_ADDR_GATE || csr_addr_i == `SC_ADDR_TCMP;

  a_ack_follows_req: assert property (csr_req_i |=>
    csr_ack_o && csr_err_o == !$past(mapped))
    else $error("ack or err wrong after request");
  a_idle_bus_quiet: assert property (!csr_req_i |=>
    !csr_ack_o && !csr_err_o && csr_rdata_o == 32'h0)
    else $error("bus outputs active without request");
  a_view_bits_only: assert property ((pend_sel || enab_sel) |=>
    (csr_rdata_o & ~32'h0000_0333) == 32'h0)
    else $error("reserved interrupt bit reads nonzero");
  a_ipi_sets_soft: assert property (ipi_i ##1 pend_sel |=>
    csr_rdata_o[`SC_BIT_SSOFT])
    else $error("interprocessor request did not set soft pending");
  a_uext_line_or: assert property (USER_IRQ_EN && user_ext_irq_i && pend_sel |=>
    csr_rdata_o[`SC_BIT_UEXT])
    else $error("user external line missing from pending read");
  a_uext_absent_zero: assert property (!USER_IRQ_EN && pend_sel |=>
    (csr_rdata_o & 32'h111) == 32'h0)
    else $error("user pending bits nonzero without user interrupts");
  a_sext_live_view: assert property (sup_ext_irq_i && pend_sel |=>
    csr_rdata_o[`SC_BIT_SEXT])
    else $error("supervisor external line missing from pending read");
  a_trap_answer: assert property (trap_pc_valid_o == $past(trap_i))
    else $error("trap target valid not one cycle after trap");
  a_target_aligned: assert property (trap_pc_valid_o |-> trap_pc_o[1:0] == 2'b00)
    else $error("trap target not word aligned");
  a_cnt_one_verdict: assert property (cnt_rd_i |=> cnt_ok_o ^ cnt_illegal_o)
    else $error("counter read verdict not exactly one");
  a_cnt_super_ok: assert property (cnt_rd_i && !user_mode_i |=> cnt_ok_o)
    else $error("counter read outside user mode refused");
  a_cnt_idle: assert property (!cnt_rd_i |=> !cnt_ok_o && !cnt_illegal_o)
    else $error("counter verdict without read");
  a_active_bits: assert property ((irq_active_o & ~32'h0000_0333) == 32'h0)
    else $error("active interrupt outside defined bits");
endmodule : sup_csr_checker

bind supervisor_trap_irq_csrs sup_csr_checker #(.USER_IRQ_EN(USER_IRQ_EN), .CAUSE_W(CAUSE_W))
  i_checker (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .csr_req_i(csr_req_i),
  .csr_addr_i(csr_addr_i), .csr_op_i(csr_op_i), .csr_wdata_i(csr_wdata_i),
  .csr_ack_o(csr_ack_o), .csr_err_o(csr_err_o), .csr_rdata_o(csr_rdata_o), .ipi_i(ipi_i),
  .sup_ext_irq_i(sup_ext_irq_i), .user_ext_irq_i(user_ext_irq_i),
  .user_timer_irq_i(user_timer_irq_i), .time_i(time_i), .irq_active_o(irq_active_o),
  .trap_i(trap_i), .trap_irq_i(trap_irq_i), .trap_cause_i(trap_cause_i),
  .trap_pc_valid_o(trap_pc_valid_o), .trap_pc_o(trap_pc_o), .cnt_rd_i(cnt_rd_i),
  .user_mode_i(user_mode_i), .cnt_idx_i(cnt_idx_i), .cnt_ok_o(cnt_ok_o),
  .cnt_illegal_o(cnt_illegal_o));
`default_nettype wire

// file: sim/irq_source_model.sv
`timescale 1ns/1ps
`default_nettype none

module irq_source_model (
  // Clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        rstn_i,
  // Requests from the bench
  input  wire logic [3:0]  line_cmd_i,
  // Lines towards the hart: ipi, sup ext, user ext, user timer
  output logic      [3:0]  lines_o,
  output logic      [31:0] time_o
);
  // The counter steps every core cycle so that compare deadlines come up quickly.
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      lines_o <= 4'h0;
      time_o  <= 32'h0;
    end else begin
      lines_o <= line_cmd_i;
      time_o  <= time_o + 32'h1;
    end
  end
endmodule : irq_source_model
`default_nettype wire

// file: sim/supervisor_trap_irq_csrs_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "sup_csr_consts.svh"

module supervisor_trap_irq_csrs_bench;
  import sup_csr_pkg::*;
  localparam logic [11:0] tvec_a = `SC_ADDR_TVEC;
  localparam logic [11:0] pend_a = `SC_ADDR_PEND;
  localparam logic [11:0] enab_a = `SC_ADDR_ENAB;
  localparam logic [11:0] gate_a = `SC_ADDR_GATE;
  localparam logic [11:0] tcmp_a = `SC_ADDR_TCMP;
  localparam logic [31:0] gate_pat = 32'h8000_0005;
  logic        ref_clk = 1'b0;
  logic        rstn = 1'b0;
  logic        csr_req = 1'b0;
  logic [11:0] csr_addr = 12'h000;
  csr_op_e     csr_op = CSR_READ;
  logic [31:0] csr_wdata = 32'h0;
  logic [3:0]  line_cmd = 4'h0;
  logic        trap = 1'b0, trap_irq = 1'b0, cnt_rd = 1'b0, user_mode = 1'b0;
  logic [4:0]  trap_cause = 5'h00, cnt_idx = 5'h00;
  logic [3:0]  lines;
  logic [31:0] time_val, rdata, rdata2, active, pc;
  logic        ack, err, pc_valid, cnt_ok, cnt_bad;
  int          fail_count = 0;
  int          checks = 0;

  always #5 ref_clk = ~ref_clk;

  irq_source_model i_irq_src (.ref_clk_i(ref_clk), .rstn_i(rstn), .line_cmd_i(line_cmd),
    .lines_o(lines), .time_o(time_val));

  supervisor_trap_irq_csrs #(.USER_IRQ_EN(1'b1), .VEC_ALIGN_BITS(2),
    .GATE_IMPL(32'hffff_ffff), .CAUSE_W(5)) i_dut (.ref_clk_i(ref_clk), .rstn_i(rstn),
    .csr_req_i(csr_req), .csr_addr_i(csr_addr), .csr_op_i(csr_op), .csr_wdata_i(csr_wdata),
    .csr_ack_o(ack), .csr_err_o(err), .csr_rdata_o(rdata), .ipi_i(lines[0]),
    .sup_ext_irq_i(lines[1]), .user_ext_irq_i(lines[2]), .user_timer_irq_i(lines[3]),
    .time_i(time_val), .irq_active_o(active), .trap_i(trap), .trap_irq_i(trap_irq),
    .trap_cause_i(trap_cause), .trap_pc_valid_o(pc_valid), .trap_pc_o(pc),
    .cnt_rd_i(cnt_rd), .user_mode_i(user_mode), .cnt_idx_i(cnt_idx), .cnt_ok_o(cnt_ok),
    .cnt_illegal_o(cnt_bad));

  // A second hart without user interrupts shares every input with the first.
  supervisor_trap_irq_csrs #(.USER_IRQ_EN(1'b0)) i_dut_nouser (.ref_clk_i(ref_clk),
    .rstn_i(rstn), .csr_req_i(csr_req), .csr_addr_i(csr_addr), .csr_op_i(csr_op),
    .csr_wdata_i(csr_wdata), .csr_ack_o(), .csr_err_o(), .csr_rdata_o(rdata2),
    .ipi_i(lines[0]), .sup_ext_irq_i(lines[1]), .user_ext_irq_i(lines[2]),
    .user_timer_irq_i(lines[3]), .time_i(time_val), .irq_active_o(), .trap_i(trap),
    .trap_irq_i(trap_irq), .trap_cause_i(trap_cause), .trap_pc_valid_o(), .trap_pc_o(),
    .cnt_rd_i(cnt_rd), .user_mode_i(user_mode), .cnt_idx_i(cnt_idx), .cnt_ok_o(),
    .cnt_illegal_o());

  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : final_report

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp

  task automatic cycles(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : cycles

  task automatic csr(input csr_op_e op, input logic [11:0] a, input logic [31:0] wd,
                     input logic [31:0] old, input logic e_err = 1'b0);
    @(posedge ref_clk);
    csr_req   <= 1'b1;
    csr_op    <= op;
    csr_addr  <= a;
    csr_wdata <= wd;
    @(posedge ref_clk);
    csr_req <= 1'b0;
    #1;
    cmp({30'h0, ack, err}, {30'h0, 1'b1, e_err});
    cmp(rdata, old);
  endtask : csr

  task automatic trap_chk(input logic irq, input logic [4:0] cause, input logic [31:0] exp);
    @(posedge ref_clk);
    trap       <= 1'b1;
    trap_irq   <= irq;
    trap_cause <= cause;
    @(posedge ref_clk);
    trap <= 1'b0;
    #1;
    cmp({31'h0, pc_valid}, 32'h1);
    cmp(pc, exp);
  endtask : trap_chk

  task automatic cnt_chk(input logic user, input logic [4:0] idx, input logic ok);
    @(posedge ref_clk);
    cnt_rd    <= 1'b1;
    user_mode <= user;
    cnt_idx   <= idx;
    @(posedge ref_clk);
    cnt_rd <= 1'b0;
    #1;
    cmp({30'h0, cnt_ok, cnt_bad}, {30'h0, ok, ~ok});
  endtask : cnt_chk

  initial begin
    #100000;
    fail_count++;
    final_report();
  end

  initial begin
    logic [11:0] regs [4] = '{tvec_a, pend_a, enab_a, gate_a};
    logic [4:0]  idxs [5] = '{5'd0, 5'd1, 5'd2, 5'd3, 5'd31};
    cycles(16);
    rstn <= 1'b1;
    cycles(3);
    foreach (regs[i]) csr(CSR_READ, regs[i], 32'h0, 32'h0);
    csr(CSR_READ, 12'h7ff, 32'h0, 32'h0, 1'b1);
    // A reserved mode keeps direct dispatch while the base is still taken.
    csr(CSR_WRITE, tvec_a, 32'h8000_1003, 32'h0);
    csr(CSR_READ, tvec_a, 32'h0, 32'h8000_1000);
    trap_chk(1'b0, 5'd2, 32'h8000_1000);
    trap_chk(1'b1, 5'd5, 32'h8000_1000);
    csr(CSR_WRITE, tvec_a, 32'h8000_1001, 32'h8000_1000);
    csr(CSR_READ, tvec_a, 32'h0, 32'h8000_1001);
    trap_chk(1'b1, 5'd5, 32'h8000_1014);
    trap_chk(1'b1, 5'd31, 32'h8000_107c);
    trap_chk(1'b0, 5'd9, 32'h8000_1000);
    trap_chk(1'b1, 5'd0, 32'h8000_1000);
    csr(CSR_WRITE, pend_a, 32'hffff_ffff, 32'h0);
    csr(CSR_READ, pend_a, 32'h0, 32'h0000_0103);
    cmp(rdata2, 32'h0000_0002);
    csr(CSR_CLEAR, pend_a, 32'h0000_0101, 32'h0000_0103);
    csr(CSR_SET, pend_a, 32'h0000_0001, 32'h0000_0002);
    csr(CSR_WRITE, pend_a, 32'h0, 32'h0000_0003);
    @(posedge ref_clk);
    line_cmd <= 4'h1;
    @(posedge ref_clk);
    line_cmd <= 4'h0;
    csr(CSR_READ, pend_a, 32'h0, 32'h0000_0002);
    csr(CSR_WRITE, pend_a, 32'h0, 32'h0000_0002);
    @(posedge ref_clk);
    line_cmd <= 4'h4;
    cycles(2);
    csr(CSR_READ, pend_a, 32'h0, 32'h0000_0100);
    csr(CSR_SET, pend_a, 32'h0, 32'h0000_0100);
    @(posedge ref_clk);
    line_cmd <= 4'h0;
    cycles(2);
    csr(CSR_READ, pend_a, 32'h0, 32'h0);
    csr(CSR_WRITE, enab_a, 32'hffff_ffff, 32'h0);
    csr(CSR_READ, enab_a, 32'h0, 32'h0000_0333);
    @(posedge ref_clk);
    line_cmd <= 4'ha;
    cycles(2);
    csr(CSR_WRITE, pend_a, 32'h0000_0103, 32'h0000_0210);
    cycles(2);
    #1;
    cmp(active, 32'h0000_0313);
    csr(CSR_WRITE, enab_a, 32'h0000_0200, 32'h0000_0333);
    cycles(2);
    #1;
    cmp(active, 32'h0000_0200);
    @(posedge ref_clk);
    line_cmd <= 4'h0;
    csr(CSR_WRITE, pend_a, 32'h0, 32'h0000_0103);
    csr(CSR_WRITE, enab_a, 32'h0000_0020, 32'h0000_0200);
    csr(CSR_WRITE, tcmp_a, 32'h0, 32'hffff_ffff);
    cycles(3);
    #1;
    cmp(active, 32'h0000_0020);
    csr(CSR_WRITE, pend_a, 32'h0, 32'h0000_0020);
    csr(CSR_READ, pend_a, 32'h0, 32'h0000_0020);
    csr(CSR_WRITE, tcmp_a, 32'hffff_ffff, 32'h0);
    cycles(2);
    csr(CSR_READ, pend_a, 32'h0, 32'h0);
    csr(CSR_WRITE, gate_a, 32'h8000_0005, 32'h0);
    csr(CSR_READ, gate_a, 32'h0, 32'h8000_0005);
    foreach (idxs[i]) cnt_chk(1'b1, idxs[i], gate_pat[idxs[i]]);
    cnt_chk(1'b0, 5'd1, 1'b1);
    final_report();
  end
endmodule : supervisor_trap_irq_csrs_bench
`default_nettype wire
